// >>> design/byte_fifo.sv
`timescale 1ns/10ps
module byte_fifo
  import msbc_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk_i,               // system clock
  input wire logic rstn_i,                  // async reset, active low
  input wire logic wr_valid_i,              // write side offers a word
  output logic wr_ready_o,                  // room for a word
  input wire logic [WIDTH-1:0] wr_data_i,   // word written
  output logic rd_valid_o,                  // a word is held
  input wire logic rd_ready_i,              // read side takes the word
  output logic [WIDTH-1:0] rd_data_o        // oldest word
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // whole fifo state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic wr_rdy;
    logic rd_vld;
  } fifo_state_type;

  fifo_state_type st_ff;   // registered state
  fifo_state_type nxt_st;  // next state
  logic push;              // word accepted
  logic pop;               // word delivered

  assign push = wr_valid_i & st_ff.wr_rdy;
  assign pop = rd_ready_i & st_ff.rd_vld;

  // pointers, storage and flags
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr_ptr] = wr_data_i;
      nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.wr_ptr + AW'(1);
    end
    if (pop) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.rd_ptr + AW'(1);
    end
    nxt_st.count = st_ff.count + CW'(push) - CW'(pop);
    nxt_st.rd_vld = (nxt_st.count != '0);
    nxt_st.wr_rdy = (nxt_st.count != CW'(DEPTH));
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wr_ready_o = st_ff.wr_rdy;
  assign rd_valid_o = st_ff.rd_vld;
  assign rd_data_o = st_ff.mem[st_ff.rd_ptr];

endmodule

// >>> design/media_byte_channel_adapter.sv
`timescale 1ns/10ps
// Summary of operation
// - byte stream framed every 125 us
// - media bytes at rows 2,3 columns 2,3,5
// - reserved positions never carry media data
// - frame holds at most six media bytes
// - unsourced media bytes are idle, not interpreted
// - source inserts fifo bytes at media slots
// - sink extracts six media bytes per frame while msb_sourced_i is set
// - unused national bytes get alternating pattern
// - optional polarization mismatch defect from canceller
module media_byte_channel_adapter
  import msbc_pkg::*;
(
  input wire logic sys_clk_i,                  // system clock, 100 MHz
  input wire logic rstn_i,                     // async reset, active low
  input wire logic frame_byte_clock_i,         // source byte strobe
  input wire beat_type tx_beat_i,              // source stream in
  output beat_type tx_beat_o,                  // source stream out
  output logic tx_byte_clock_o,                // strobe for tx_beat_o
  input wire logic [7:0] media_channel_data_i, // media byte to send
  input wire logic media_channel_valid_i,      // media byte offered
  output logic media_channel_ready_o,          // media byte taken
  input wire logic national_use_unused_i,      // fill national bytes
  input wire logic rx_byte_clock_i,            // sink byte strobe
  input wire beat_type rx_beat_i,              // sink stream in
  input wire logic msb_sourced_i,              // far end sources media
  output logic [7:0] media_channel_data_o,     // media byte received
  output logic media_channel_valid_o,          // received byte pulse
  output logic [2:0] media_channel_slot_o,     // slot 0..5 of that byte
  input wire logic cross_polar_canceller_en_i, // canceller fitted
  input wire logic main_signal_lost_i,         // main path lost
  input wire logic cross_polar_received_i,     // cross path seen as main
  output logic polarization_mismatch_defect_o  // mismatch defect level
);

  // whole block state
  typedef struct packed {
    pos_type tx_pos;      // position of last source byte
    beat_type tx_beat;    // outgoing byte
    logic tx_clk;         // outgoing strobe
    pos_type rx_pos;      // position of last sink byte
    logic [7:0] rx_data;  // extracted byte
    logic rx_vld;         // extracted byte pulse
    logic [2:0] rx_slot;  // extracted slot
    logic mismatch;       // mismatch defect
  } state_type;

  state_type st_ff;     // registered state
  state_type nxt_st;    // next state
  pos_type tx_cur;      // position of current source byte
  pos_type rx_cur;      // position of current sink byte
  slot_type tx_slot;    // media slot at source
  slot_type rx_slot;    // media slot at sink
  logic national_fill;  // national byte to be filled
  logic fifo_vld;       // media byte waiting
  logic fifo_pop;       // media byte consumed
  logic [7:0] fifo_data; // head media byte

  // media bytes wait here until their slot comes round
  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_media_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .wr_valid_i(media_channel_valid_i),
    .wr_ready_o(media_channel_ready_o),
    .wr_data_i(media_channel_data_i),
    .rd_valid_o(fifo_vld),
    .rd_ready_i(fifo_pop),
    .rd_data_o(fifo_data)
  );

  assign tx_cur = tx_beat_i.frame_start_pulse ? pos_type'({FIRST_ROW, FIRST_COL})
                                              : next_pos(st_ff.tx_pos);
  assign rx_cur = rx_beat_i.frame_start_pulse ? pos_type'({FIRST_ROW, FIRST_COL})
                                              : next_pos(st_ff.rx_pos);

  assign tx_slot = msb_slot(tx_cur);
  assign rx_slot = msb_slot(rx_cur);
  assign national_fill = is_national(tx_cur) & national_use_unused_i;

  // take a media byte only in its slot
  assign fifo_pop = frame_byte_clock_i & tx_slot.hit & fifo_vld;

  // next state of both directions
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tx_clk = frame_byte_clock_i;
    nxt_st.rx_vld = 1'b0;
    // source side: one byte per strobe
    if (frame_byte_clock_i) begin
      nxt_st.tx_pos = tx_cur;
      nxt_st.tx_beat = tx_beat_i;
      if (tx_slot.hit) begin
        // idle fill when nothing is queued
        nxt_st.tx_beat.section_adapted_data = fifo_vld ? fifo_data : MSB_IDLE_BYTE;
      end else if (national_fill) begin
        nxt_st.tx_beat.section_adapted_data = NATIONAL_FILL_BYTE;
      end
    end
    // sink side: one byte per strobe
    if (rx_byte_clock_i) begin
      nxt_st.rx_pos = rx_cur;
      // extract media bytes, only when sourced
      if (rx_slot.hit && msb_sourced_i) begin
        nxt_st.rx_data = rx_beat_i.section_adapted_data;
        nxt_st.rx_slot = rx_slot.slot;
        nxt_st.rx_vld = 1'b1;
      end
    end
    nxt_st.mismatch = cross_polar_canceller_en_i &
                 (main_signal_lost_i | cross_polar_received_i);
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign tx_beat_o = st_ff.tx_beat;
  assign tx_byte_clock_o = st_ff.tx_clk;
  assign media_channel_data_o = st_ff.rx_data;
  assign media_channel_valid_o = st_ff.rx_vld;
  assign media_channel_slot_o = st_ff.rx_slot;
  assign polarization_mismatch_defect_o = st_ff.mismatch;

  // helper: media slots seen since frame start
  logic [3:0] msb_seen_ff;

  // count source media slots per frame
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      msb_seen_ff <= 4'h0;
    end else if (frame_byte_clock_i) begin
      if (tx_beat_i.frame_start_pulse) begin
        msb_seen_ff <= {3'h0, tx_slot.hit};
      end else begin
        msb_seen_ff <= msb_seen_ff + {3'h0, tx_slot.hit};
      end
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_frame_wrap: assert property (
    (frame_byte_clock_i && !tx_beat_i.frame_start_pulse &&
     st_ff.tx_pos == pos_type'({LAST_ROW, LAST_COL}))
    |=> st_ff.tx_pos == pos_type'({FIRST_ROW, FIRST_COL}))
    else $error("frame position did not wrap");

  a_sink_slot_only: assert property (
    (rx_byte_clock_i && !rx_slot.hit) |=> !media_channel_valid_o)
    else $error("media byte taken outside its slot");

  a_reserved_keep: assert property (
    (frame_byte_clock_i && is_reserved(tx_cur))
    |=> tx_beat_o == $past(tx_beat_i))
    else $error("reserved byte was altered");

  a_six_per_frame: assert property (
    msb_seen_ff <= 4'(MSB_BYTES))
    else $error("more than six media slots in a frame");

  a_idle_fill: assert property (
    (frame_byte_clock_i && tx_slot.hit && !fifo_vld)
    |=> tx_beat_o.section_adapted_data == MSB_IDLE_BYTE)
    else $error("empty media slot not idle filled");

  a_media_insert: assert property (
    (frame_byte_clock_i && tx_slot.hit && fifo_vld)
    |=> tx_byte_clock_o && tx_beat_o.section_adapted_data == $past(fifo_data))
    else $error("queued media byte not inserted");

  a_sink_extract: assert property (
    (rx_byte_clock_i && rx_slot.hit && msb_sourced_i)
    |=> media_channel_valid_o && media_channel_slot_o == $past(rx_slot.slot) &&
        media_channel_data_o == $past(rx_beat_i.section_adapted_data))
    else $error("media byte not extracted");

  a_national_fill: assert property (
    (frame_byte_clock_i && national_fill)
    |=> tx_beat_o.section_adapted_data == NATIONAL_FILL_BYTE)
    else $error("unused national byte not filled");

  a_defect_follow: assert property (
    (cross_polar_canceller_en_i && main_signal_lost_i) ##1 cross_polar_canceller_en_i
    |-> polarization_mismatch_defect_o)
    else $error("mismatch defect missed");

  a_pass_through: assert property (
    (frame_byte_clock_i && !tx_slot.hit && !national_fill)
    |=> tx_beat_o == $past(tx_beat_i) && tx_byte_clock_o)
    else $error("payload byte was altered");

  c_media_sent: cover property (fifo_pop);
  c_idle_slot: cover property (frame_byte_clock_i && tx_slot.hit && !fifo_vld);
  c_last_slot: cover property (media_channel_valid_o && media_channel_slot_o == 3'h5);
  c_defect_seen: cover property (polarization_mismatch_defect_o);

endmodule

// >>> design/msbc_pkg.sv
package msbc_pkg;

  // frame geometry: 9 rows of 270 byte columns every 125 us
  localparam int FRAME_ROWS = 9;
  localparam int FRAME_COLS = 270;
  localparam int FRAME_PERIOD_US = 125;
  localparam int FRAME_BYTES = FRAME_ROWS * FRAME_COLS;
  // makeup of the adapted information per frame
  localparam int MS_BYTES = 2403;
  localparam int DCC_BYTES = 3;
  localparam int OW_BYTES = 1;
  localparam int USER_BYTES = 1;
  localparam int MSB_BYTES = 6;

  // media channel fifo shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  // position counter limits
  localparam logic [3:0] FIRST_ROW = 4'h1;
  localparam logic [3:0] LAST_ROW = 4'h9;
  localparam logic [8:0] FIRST_COL = 9'h001;
  localparam logic [8:0] LAST_COL = 9'h10E;

  // media specific byte positions (rows 2 and 3)
  localparam logic [3:0] MSB_ROW_LO = 4'h2;
  localparam logic [3:0] MSB_ROW_HI = 4'h3;
  localparam logic [8:0] MSB_COL_A = 9'h002;
  localparam logic [8:0] MSB_COL_B = 9'h003;
  localparam logic [8:0] MSB_COL_C = 9'h005;

  // reserved positions: [2,6] and [3,6], [3,8], [3,9]
  localparam logic [8:0] RSV_COL_A = 9'h006;
  localparam logic [8:0] RSV_COL_B = 9'h008;
  localparam logic [8:0] RSV_COL_C = 9'h009;

  // national use bytes that bypass the scrambler
  localparam logic [3:0] NATIONAL_ROW = 4'h1;
  localparam logic [8:0] NATIONAL_COL_A = 9'h008;
  localparam logic [8:0] NATIONAL_COL_B = 9'h009;

  // fill values and reset values
  localparam logic [7:0] NATIONAL_FILL_BYTE = 8'hAA;
  localparam logic [7:0] MSB_IDLE_BYTE = 8'h55;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // row and column of one frame byte
  typedef struct packed {
    logic [3:0] row;
    logic [8:0] col;
  } pos_type;

  // one byte of the section stream with its frame marker
  typedef struct packed {
    logic frame_start_pulse;
    logic [7:0] section_adapted_data;
  } beat_type;

  // media slot decode result
  typedef struct packed {
    logic hit;
    logic [2:0] slot;
  } slot_type;

  // advance one byte through the frame
  function automatic pos_type next_pos(pos_type p);
    pos_type n;
    n = p;
    if (p.col == LAST_COL) begin
      n.col = FIRST_COL;
      n.row = (p.row == LAST_ROW) ? FIRST_ROW : p.row + 4'h1;
    end else begin
      n.col = p.col + 9'h001;
    end
    return n;
  endfunction

  // media slot number 0..5 for a position
  function automatic slot_type msb_slot(pos_type p);
    slot_type s;
    s = '0;
    if ((p.row == MSB_ROW_LO) || (p.row == MSB_ROW_HI)) begin
      s.hit = (p.col == MSB_COL_A) || (p.col == MSB_COL_B) || (p.col == MSB_COL_C);
      s.slot = (p.row == MSB_ROW_HI) ? 3'h3 : 3'h0;
      if (p.col == MSB_COL_B) begin
        s.slot = s.slot + 3'h1;
      end
      if (p.col == MSB_COL_C) begin
        s.slot = s.slot + 3'h2;
      end
    end
    return s;
  endfunction

  // reserved positions that stay untouched
  function automatic logic is_reserved(pos_type p);
    return ((p.row == MSB_ROW_LO) && (p.col == RSV_COL_A)) ||
           ((p.row == MSB_ROW_HI) && ((p.col == RSV_COL_A) ||
            (p.col == RSV_COL_B) || (p.col == RSV_COL_C)));
  endfunction

  // national use byte positions
  function automatic logic is_national(pos_type p);
    return (p.row == NATIONAL_ROW) &&
           ((p.col == NATIONAL_COL_A) || (p.col == NATIONAL_COL_B));
  endfunction

endpackage

// >>> sim/frame_feed.sv
`timescale 1ns/10ps
// far side model: section termination sending whole frames, one byte each cycle
module frame_feed
  import msbc_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  output logic strobe_o,      // byte strobe
  output beat_type beat_o     // byte and frame marker
);
  // quiet line at time zero
  initial begin
    strobe_o = 1'b0;
    beat_o = '0;
  end

  // one frame, frame marker on the first byte, bytes back to back
  // octet stream framed by fs
  task automatic send_frame();
    for (int i = 0; i < FRAME_BYTES; i++) begin
      @(posedge sys_clk_i);
      #1;
      strobe_o = 1'b1;
      beat_o.frame_start_pulse = (i == 0);
      beat_o.section_adapted_data = 8'(i * 7 + i / 270);
    end
    @(posedge sys_clk_i);
    #1;
    strobe_o = 1'b0;
    // released line shows the inverse, never the last byte
    beat_o = ~beat_o;
  endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/10ps
// self-checking bench for the media byte channel adapter
module tb;
  import msbc_pkg::*;
  logic sys_clk_i, rstn_i, fstb, tx_byte_clock_o, ready_o, valid_i, natl_i, src_i;
  logic en_i, lost_i, xrx_i, valid_o, defect_o, prev_stb;
  logic [7:0] data_i, data_o;
  logic [2:0] slot_o;
  beat_type fbeat, tx_beat_o, e;
  beat_type texp[$]; // expected source output bytes
  logic [10:0] rexp[$]; // expected sink slot and byte
  logic [7:0] mq[$]; // model of queued media bytes
  int err_count, samples_checked, cycles, row, col, slot;

  frame_feed u_feed (.sys_clk_i(sys_clk_i), .strobe_o(fstb), .beat_o(fbeat));

  media_byte_channel_adapter u_dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .frame_byte_clock_i(fstb), .tx_beat_i(fbeat),
    .tx_beat_o(tx_beat_o), .tx_byte_clock_o(tx_byte_clock_o), .media_channel_data_i(data_i),
    .media_channel_valid_i(valid_i), .media_channel_ready_o(ready_o),
    .national_use_unused_i(natl_i), .rx_byte_clock_i(fstb), .rx_beat_i(fbeat),
    .msb_sourced_i(src_i), .media_channel_data_o(data_o), .media_channel_valid_o(valid_o),
    .media_channel_slot_o(slot_o), .cross_polar_canceller_en_i(en_i),
    .main_signal_lost_i(lost_i), .cross_polar_received_i(xrx_i),
    .polarization_mismatch_defect_o(defect_o));

  // 100 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // one comparison, counted
  task automatic chk(string nm, logic [11:0] ex, logic [11:0] got);
    samples_checked++;
    if (got !== ex) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // monitor: tracks frame position and predicts both directions
  // runs on the falling edge so that inputs and registered outputs are settled
  always @(negedge sys_clk_i) begin
    cycles++;
    if (cycles > 10000) begin
      err_count++;
      close_out();
    end
    if (valid_i && ready_o) mq.push_back(data_i);
    if (rstn_i) chk("tx_strobe", 12'(prev_stb), 12'(tx_byte_clock_o));
    prev_stb = fstb;
    if (tx_byte_clock_o && texp.size() > 0) chk("tx_beat", texp.pop_front(), tx_beat_o);
    if (valid_o) begin
      if (rexp.size() > 0) chk("rx_byte", rexp.pop_front(), {slot_o, data_o});
      else chk("rx_spurious", 12'h000, 12'h001);
    end
    if (fstb) begin
      if (fbeat.frame_start_pulse) begin
        row = 1;
        col = 1;
      end else if (col == 270) begin
        col = 1;
        row = (row == 9) ? 1 : row + 1;
      end else col++;
      slot = -1;
      if (row == 2 || row == 3) begin
        case (col)
          2: slot = 0;
          3: slot = 1;
          5: slot = 2;
          default: slot = -1;
        endcase
        if (slot >= 0 && row == 3) slot += 3;
      end
      e = fbeat;
      // only the six slots carry media bytes
      if (slot >= 0) begin
        e.section_adapted_data = (mq.size() > 0) ? mq.pop_front() : 8'h55;
        if (src_i) rexp.push_back({3'(slot), fbeat.section_adapted_data});
      end else if (row == 1 && (col == 8 || col == 9) && natl_i) begin
        e.section_adapted_data = 8'hAA;
      end
      texp.push_back(e);
    end
  end

  // fill the media fifo until it refuses
  task automatic s_fill();
    int k;
    k = 0;
    valid_i = 1'b1;
    data_i = 8'hC0;
    for (int i = 0; i < 20; i++) begin
      if (ready_o) k++;
      @(posedge sys_clk_i);
      #1;
      data_i = 8'hC0 + 8'(k);
    end
    valid_i = 1'b0;
    chk("accepted", 12'h008, 12'(k));
    chk("ready_full", 12'h000, 12'(ready_o));
  endtask

  // one frame through both sides, then judge leftovers
  task automatic s_frame(logic natl, logic src, int left);
    natl_i = natl;
    src_i = src;
    u_feed.send_frame();
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk("tx_left", 12'h000, 12'(texp.size()));
    chk("rx_left", 12'h000, 12'(rexp.size()));
    chk("fifo_left", 12'(left), 12'(mq.size()));
  endtask

  // every combination of the canceller inputs
  task automatic s_defect();
    for (int i = 0; i < 8; i++) begin
      {en_i, lost_i, xrx_i} = 3'(i);
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("defect", 12'(en_i & (lost_i | xrx_i)), 12'(defect_o));
    end
  endtask

  // main sequence
  initial begin
    rstn_i = 1'b0;
    {valid_i, natl_i, src_i, en_i, lost_i, xrx_i, prev_stb} = '0;
    data_i = 8'h00;
    repeat (10) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    s_fill();
    s_frame(1'b1, 1'b1, 2);
    s_frame(1'b0, 1'b0, 0);
    chk("ready_drained", 12'h001, 12'(ready_o));
    s_defect();
    close_out();
  end
endmodule
